// ### rtl/ifb_pkg.sv
/*
 * Shared constants of the interrupt flag bank: register offsets, select codes,
 * implemented-bit masks, field positions and reset values.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package ifb_pkg;

	// Bus geometry.
	localparam int unsigned IFB_DATA_W     = 32;
	localparam int unsigned IFB_FLAG_W     = 16;
	localparam int unsigned IFB_EVT_W      = 3;
	localparam int unsigned IFB_OFF_W      = 4;
	localparam int unsigned IFB_MIN_ADDR_W = 4;

	// Byte offsets of the registers.
	localparam logic [3:0] IFB_OFF_FLAGS_ONE = 4'h0;
	localparam logic [3:0] IFB_OFF_FLAGS_TWO = 4'h4;
	localparam logic [3:0] IFB_OFF_EVT_STAT  = 4'h8;
	localparam logic [3:0] IFB_OFF_EVT_MASK  = 4'hC;

	// Register select codes produced by the address decoder.
	localparam logic [2:0] IFB_SEL_FLAGS_ONE = 3'h0;
	localparam logic [2:0] IFB_SEL_FLAGS_TWO = 3'h1;
	localparam logic [2:0] IFB_SEL_EVT_STAT  = 3'h2;
	localparam logic [2:0] IFB_SEL_EVT_MASK  = 3'h3;
	localparam logic [2:0] IFB_SEL_NONE      = 3'h4;

	// Implemented flag bits; the holes always read as zero.
	localparam logic [15:0] IFB_IMPL_ONE = 16'hFFFB;
	localparam logic [15:0] IFB_IMPL_TWO = 16'hDFFF;
	localparam int unsigned IFB_HOLE_ONE = 2;
	localparam int unsigned IFB_HOLE_TWO = 13;

	// Selected field positions in the first flag register.
	localparam int unsigned IFB_B1_UART_B_TX   = 15;
	localparam int unsigned IFB_B1_EXT_IRQ_B   = 13;
	localparam int unsigned IFB_B1_DMA_CH_TWO  = 8;
	localparam int unsigned IFB_B1_ADC_B_DONE  = 5;
	localparam int unsigned IFB_B1_I2C_A_MSTR  = 1;

	// Selected field positions in the second flag register.
	localparam int unsigned IFB_B2_TIMER_SIX   = 15;
	localparam int unsigned IFB_B2_COMPARE_8   = 12;
	localparam int unsigned IFB_B2_CAN_A_EVENT = 3;

	// Event status bits.
	localparam int unsigned IFB_EV_REQ_ONE = 0;
	localparam int unsigned IFB_EV_REQ_TWO = 1;
	localparam int unsigned IFB_EV_COLLIDE = 2;

	// Reset values and bus responses.
	localparam logic [15:0] IFB_FLAGS_RST = 16'h0000;
	localparam logic [2:0]  IFB_EVT_RST   = 3'h0;
	localparam logic [1:0]  IFB_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  IFB_RESP_SLVERR = 2'h2;

endpackage

// ### rtl/ifb_flag_bank.sv
/*
 * Two 16-bit interrupt flag registers with an AXI4-Lite slave, an event
 * status register with mask and one level interrupt output.
 * Assumes request inputs are one-cycle pulses synchronous to clk.
 */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns

module ifb_flag_bank
	import ifb_pkg::*;
#(
	parameter int unsigned ADDR_WIDTH = 8
) (
	// Clock and reset.
	input  wire logic                      clk,
	input  wire logic                      rst,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_WIDTH-1:0]     s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [ifb_pkg::IFB_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_WIDTH-1:0]     s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [ifb_pkg::IFB_DATA_W-1:0] s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Peripheral request pulses, bit for bit as the flag registers.
	input  wire logic [ifb_pkg::IFB_FLAG_W-1:0] reqOne,
	input  wire logic [ifb_pkg::IFB_FLAG_W-1:0] reqTwo,
	// Flag state for the priority logic, and the interrupt line.
	output logic [ifb_pkg::IFB_FLAG_W-1:0] flagsOne,
	output logic [ifb_pkg::IFB_FLAG_W-1:0] flagsTwo,
	output logic                           irq
);
	import ifb_pkg::*;

	if (ADDR_WIDTH < IFB_MIN_ADDR_W) begin : g_addr_check
		$error("ADDR_WIDTH too small for the register map");
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Unaligned or out-of-map addresses decode to no register.
	function automatic logic [2:0] regSelect(input logic [ADDR_WIDTH-1:0] a);
		logic [2:0] sel;
		sel = IFB_SEL_NONE;
		if ((a >> IFB_OFF_W) == '0) begin
			case (a[IFB_OFF_W-1:0])
				IFB_OFF_FLAGS_ONE: sel = IFB_SEL_FLAGS_ONE;
				IFB_OFF_FLAGS_TWO: sel = IFB_SEL_FLAGS_TWO;
				IFB_OFF_EVT_STAT:  sel = IFB_SEL_EVT_STAT;
				IFB_OFF_EVT_MASK:  sel = IFB_SEL_EVT_MASK;
				default:           sel = IFB_SEL_NONE;
			endcase
		end
		return sel;
	endfunction

	function automatic logic [15:0] mergeWrite(input logic [15:0] old,
	                                           input logic [15:0] data,
	                                           input logic [15:0] mask);
		return (old & ~mask) | (data & mask);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Write channels.

	logic [ADDR_WIDTH-1:0] wrAddr;
	logic [15:0]           wrData;
	logic [1:0]            wrStrb;
	logic                  awHeld;
	logic                  wHeld;
	logic                  doWrite;
	logic [2:0]            wrSel;
	logic [15:0]           wrMask;

	// Address and data are taken in either order and held until both exist.
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign doWrite       = awHeld && wHeld;
	assign wrSel         = regSelect(wrAddr);
	assign wrMask        = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			wrAddr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			wrAddr <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wHeld  <= 1'b0;
			wrData <= '0;
			wrStrb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld  <= 1'b1;
			wrData <= s_axi_wdata[15:0];
			wrStrb <= s_axi_wstrb[1:0];
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= IFB_RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wrSel == IFB_SEL_NONE) ? IFB_RESP_SLVERR : IFB_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag registers.

	logic [15:0] wrValOne;
	logic [15:0] wrValTwo;
	logic        wrOne;
	logic        wrTwo;
	logic [15:0] next_flagsOne;
	logic [15:0] next_flagsTwo;
	logic        collide;

	assign wrOne    = doWrite && (wrSel == IFB_SEL_FLAGS_ONE);
	assign wrTwo    = doWrite && (wrSel == IFB_SEL_FLAGS_TWO);
	assign wrValOne = mergeWrite(flagsOne, wrData, wrMask) & IFB_IMPL_ONE;
	assign wrValTwo = mergeWrite(flagsTwo, wrData, wrMask) & IFB_IMPL_TWO;

	// Requests are ORed after the write so a pulse is never lost to a clear.
	always_comb begin
		next_flagsOne = wrOne ? wrValOne : flagsOne;
		next_flagsTwo = wrTwo ? wrValTwo : flagsTwo;
		next_flagsOne = (next_flagsOne | reqOne) & IFB_IMPL_ONE;
		next_flagsTwo = (next_flagsTwo | reqTwo) & IFB_IMPL_TWO;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flagsOne <= IFB_FLAGS_RST;
			flagsTwo <= IFB_FLAGS_RST;
		end else begin
			flagsOne <= next_flagsOne;
			flagsTwo <= next_flagsTwo;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event status, mask and interrupt.

	logic [2:0] evtStatus;
	logic [2:0] evtMask;
	logic [2:0] evtSet;
	logic [2:0] evtClr;

	// A collision is a request landing on a bit that software is writing.
	assign collide = (wrOne && |(reqOne & IFB_IMPL_ONE & wrMask))
	              || (wrTwo && |(reqTwo & IFB_IMPL_TWO & wrMask));

	always_comb begin
		evtSet                 = '0;
		evtSet[IFB_EV_REQ_ONE] = |(reqOne & IFB_IMPL_ONE);
		evtSet[IFB_EV_REQ_TWO] = |(reqTwo & IFB_IMPL_TWO);
		evtSet[IFB_EV_COLLIDE] = collide;
		evtClr = '0;
		if (doWrite && wrSel == IFB_SEL_EVT_STAT) begin
			evtClr = wrData[2:0] & wrMask[2:0];
		end
	end

	// Set wins over the write-one clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			evtStatus <= IFB_EVT_RST;
		end else begin
			evtStatus <= (evtStatus & ~evtClr) | evtSet;
		end
	end

	// Only the low event bits exist, so the rest of the merged word is dropped.
	logic [15:0] maskWrVal;
	assign maskWrVal = mergeWrite({13'h0000, evtMask}, wrData, wrMask);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			evtMask <= IFB_EVT_RST;
		end else if (doWrite && wrSel == IFB_SEL_EVT_MASK) begin
			evtMask <= maskWrVal[IFB_EVT_W-1:0];
		end
	end

	assign irq = |(evtStatus & evtMask);

	////////////////////////////////////////////////////////////////////////////
	// Read channels.

	logic [15:0] rdVal;
	logic [2:0]  rdSel;

	assign s_axi_arready = !s_axi_rvalid;
	assign rdSel         = regSelect(s_axi_araddr);

	always_comb begin
		case (rdSel)
			IFB_SEL_FLAGS_ONE: rdVal = flagsOne;
			IFB_SEL_FLAGS_TWO: rdVal = flagsTwo;
			IFB_SEL_EVT_STAT:  rdVal = {13'h0000, evtStatus};
			IFB_SEL_EVT_MASK:  rdVal = {13'h0000, evtMask};
			default:           rdVal = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= IFB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, rdVal};
			s_axi_rresp  <= (rdSel == IFB_SEL_NONE) ? IFB_RESP_SLVERR : IFB_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_req_sets_any;
		|(reqOne & IFB_IMPL_ONE) |=>
			((flagsOne & $past(reqOne) & IFB_IMPL_ONE) == ($past(reqOne) & IFB_IMPL_ONE));
	endproperty
	a_req_sets_any: assert property (p_req_sets_any) else $error("flag missed request");

	property p_reset_zero;
		$past(rst) |-> (flagsOne == 16'h0000) && (flagsTwo == 16'h0000);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

	property p_uart_b_tx;
		reqOne[IFB_B1_UART_B_TX] |=> flagsOne[IFB_B1_UART_B_TX] ##1 flagsOne[IFB_B1_UART_B_TX]
			|| $past(wrOne);
	endproperty
	a_uart_b_tx: assert property (p_uart_b_tx) else $error("uart tx flag wrong");

	property p_ext_irq_b;
		reqOne[IFB_B1_EXT_IRQ_B] |=> flagsOne[IFB_B1_EXT_IRQ_B];
	endproperty
	a_ext_irq_b: assert property (p_ext_irq_b) else $error("ext irq flag wrong");

	property p_dma_two;
		reqOne[IFB_B1_DMA_CH_TWO] |=> flagsOne[IFB_B1_DMA_CH_TWO];
	endproperty
	a_dma_two: assert property (p_dma_two) else $error("dma two flag wrong");

	property p_adc_b;
		reqOne[IFB_B1_ADC_B_DONE] && !wrOne |=> $rose(flagsOne[IFB_B1_ADC_B_DONE])
			|| $past(flagsOne[IFB_B1_ADC_B_DONE]);
	endproperty
	a_adc_b: assert property (p_adc_b) else $error("adc flag wrong");

	property p_holes_zero;
		!flagsOne[IFB_HOLE_ONE] && !flagsTwo[IFB_HOLE_TWO];
	endproperty
	a_holes_zero: assert property (p_holes_zero) else $error("unimplemented bit set");

	property p_timer_six;
		reqTwo[IFB_B2_TIMER_SIX] |=> flagsTwo[IFB_B2_TIMER_SIX];
	endproperty
	a_timer_six: assert property (p_timer_six) else $error("timer six flag wrong");

	property p_compare_8;
		reqTwo[IFB_B2_COMPARE_8] |=> flagsTwo[IFB_B2_COMPARE_8];
	endproperty
	a_compare_8: assert property (p_compare_8) else $error("compare eight flag wrong");

	property p_can_a;
		reqTwo[IFB_B2_CAN_A_EVENT] |=> flagsTwo[IFB_B2_CAN_A_EVENT];
	endproperty
	a_can_a: assert property (p_can_a) else $error("can event flag wrong");

	property p_sw_write;
		wrOne && (reqOne == 16'h0000) |=> flagsOne ==
			((($past(flagsOne) & ~$past(wrMask)) | ($past(wrData) & $past(wrMask))) & IFB_IMPL_ONE);
	endproperty
	a_sw_write: assert property (p_sw_write) else $error("write not stored");

	property p_collide_wins;
		wrTwo && |(reqTwo & IFB_IMPL_TWO) |=>
			((flagsTwo & $past(reqTwo) & IFB_IMPL_TWO) == ($past(reqTwo) & IFB_IMPL_TWO))
			&& (!(|$past(reqTwo & wrMask & IFB_IMPL_TWO)) || evtStatus[IFB_EV_COLLIDE]);
	endproperty
	a_collide_wins: assert property (p_collide_wins) else $error("request lost");

	property p_req_sets_two;
		|(reqTwo & IFB_IMPL_TWO) |=>
			((flagsTwo & $past(reqTwo) & IFB_IMPL_TWO) == ($past(reqTwo) & IFB_IMPL_TWO));
	endproperty
	a_req_sets_two: assert property (p_req_sets_two) else $error("flag missed request");

	property p_flags_hold;
		!wrOne && (reqOne == 16'h0000) |=> flagsOne == $past(flagsOne);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flag changed untouched");

	property p_collide_one;
		wrOne && |(reqOne & IFB_IMPL_ONE) |=>
			((flagsOne & $past(reqOne) & IFB_IMPL_ONE) == ($past(reqOne) & IFB_IMPL_ONE))
			&& (!(|$past(reqOne & wrMask & IFB_IMPL_ONE)) || evtStatus[IFB_EV_COLLIDE]);
	endproperty
	a_collide_one: assert property (p_collide_one) else $error("request lost");

endmodule // ifb_flag_bank

// ### testbench/ifb_source_model.sv
/*
 * Far-side model: the peripheral sources that raise one-cycle request pulses.
 * Assumes the bench calls fire between clock edges, never at a rising edge.
 */
`timescale 1ns/1ns
module ifb_source_model
	import ifb_pkg::*;
(
	// Clock and reset.
	input  wire logic                           clk,
	input  wire logic                           rst,
	// Request pulses toward the flag bank.
	output logic [ifb_pkg::IFB_FLAG_W-1:0]      reqOne = '0,
	output logic [ifb_pkg::IFB_FLAG_W-1:0]      reqTwo = '0
);
	logic [IFB_FLAG_W-1:0] pendOne = '0;
	logic [IFB_FLAG_W-1:0] pendTwo = '0;

	////////////////////////////////////////////////////////////////////////////
	// A pending request goes out for exactly one cycle, then the line idles low.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reqOne <= '0;
			reqTwo <= '0;
		end else begin
			reqOne <= pendOne;
			reqTwo <= pendTwo;
			pendOne = '0;
			pendTwo = '0;
		end
	end

	task automatic fire(input logic [15:0] a, input logic [15:0] b);
		pendOne = a;
		pendTwo = b;
	endtask
endmodule // ifb_source_model

// ### testbench/interrupt_flag_bank_one_two_tb.sv
/*
 * Self-checking bench for the flag bank: AXI4-Lite tasks and request pulses.
 * Assumes the response channels may be left ready throughout.
 */
`timescale 1ns/1ns
module interrupt_flag_bank_one_two_tb;
	import ifb_pkg::*;
	logic        clk, rst, awValid, wValid, bReady, arValid, rReady;
	logic        awReady, wReady, bValid, arReady, rValid, irq;
	logic [7:0]  awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp;
	logic [15:0] reqOne, reqTwo, flagsOne, flagsTwo;
	int          num_errors, compares, i;
	localparam logic [7:0] A1 = {4'h0, IFB_OFF_FLAGS_ONE};
	localparam logic [7:0] A2 = {4'h0, IFB_OFF_FLAGS_TWO};
	localparam logic [7:0] AS = {4'h0, IFB_OFF_EVT_STAT};
	localparam logic [7:0] AM = {4'h0, IFB_OFF_EVT_MASK};

	ifb_flag_bank #(.ADDR_WIDTH(8)) u_ifb_flag_bank (.clk(clk), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .reqOne(reqOne),
		.reqTwo(reqTwo), .flagsOne(flagsOne), .flagsTwo(flagsTwo), .irq(irq));
	ifb_source_model u_ifb_source_model (.clk(clk), .rst(rst), .reqOne(reqOne),
		.reqTwo(reqTwo));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Channels are sampled at the falling edge, so the rising edge that takes
	// them never races with the design's own updates.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [15:0] hit, input logic [1:0] er);
		logic awDone, wDone, tkAw, tkW, bSeen;
		int n;
		awAddr <= a;
		wData <= d;
		wStrb <= s;
		awValid <= 1'b1;
		wValid <= 1'b1;
		awDone = 1'b0;
		wDone = 1'b0;
		bSeen = 1'b0;
		for (n = 0; n < 64 && !bSeen; n++) begin
			@(negedge clk);
			tkAw = awValid && awReady;
			tkW = wValid && wReady;
			if (!(awDone && wDone) && (awDone || tkAw) && (wDone || tkW))
				u_ifb_source_model.fire(hit & {16{a == A1}}, hit & {16{a == A2}});
			if (awDone && wDone && bValid === 1'b1) begin
				bSeen = 1'b1;
				chk_resp(bResp, er);
			end
			@(posedge clk);
			if (tkAw) begin
				awValid <= 1'b0;
				awDone = 1'b1;
			end
			if (tkW) begin
				wValid <= 1'b0;
				wDone = 1'b1;
			end
		end
		if (!bSeen) begin
			chk_val(32'h0, 32'h1);
			test_done();
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic arDone, rSeen;
		int n;
		arAddr <= a;
		arValid <= 1'b1;
		arDone = 1'b0;
		rSeen = 1'b0;
		for (n = 0; n < 64 && !rSeen; n++) begin
			@(negedge clk);
			if (arDone && rValid === 1'b1) begin
				rSeen = 1'b1;
				chk_val(rData, e);
				chk_resp(rResp, er);
			end
			@(posedge clk);
			if (!arDone && arReady === 1'b1) begin
				arValid <= 1'b0;
				arDone = 1'b1;
			end
		end
		if (!rSeen) begin
			chk_val(32'h0, 32'h1);
			test_done();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{awValid, wValid, arValid, awAddr, arAddr, wData, wStrb} = '0;
		bReady = 1'b1;
		rReady = 1'b1;
		num_errors = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(A1, 32'h0, IFB_RESP_OKAY);
		rd_chk(A2, 32'h0, IFB_RESP_OKAY);
		$display("test reset values ended");
		for (i = 0; i < 16; i++) begin
			@(negedge clk);
			u_ifb_source_model.fire(16'h0001 << i, 16'h0001 << i);
			repeat (2) @(posedge clk);
			rd_chk(A1, {16'h0, IFB_IMPL_ONE & (16'h0001 << i)}, IFB_RESP_OKAY);
			rd_chk(A2, {16'h0, IFB_IMPL_TWO & (16'h0001 << i)}, IFB_RESP_OKAY);
			chk_val({16'h0, flagsOne}, {16'h0, IFB_IMPL_ONE & (16'h0001 << i)});
			chk_val({16'h0, flagsTwo}, {16'h0, IFB_IMPL_TWO & (16'h0001 << i)});
			axi_write(A1, 32'h0, 4'hF, 16'h0, IFB_RESP_OKAY);
			axi_write(A2, 32'h0, 4'hF, 16'h0, IFB_RESP_OKAY);
			rd_chk(A1, 32'h0, IFB_RESP_OKAY);
			rd_chk(A2, 32'h0, IFB_RESP_OKAY);
		end
		$display("test request walk ended");
		axi_write(A1, 32'hFFFFFFFF, 4'hF, 16'h0, IFB_RESP_OKAY);
		axi_write(A2, 32'hFFFFFFFF, 4'h1, 16'h0, IFB_RESP_OKAY);
		rd_chk(A1, {16'h0, IFB_IMPL_ONE}, IFB_RESP_OKAY);
		rd_chk(A2, 32'h000000FF, IFB_RESP_OKAY);
		$display("test software write ended");
		axi_write(AS, 32'h7, 4'hF, 16'h0, IFB_RESP_OKAY);
		axi_write(A1, 32'h0, 4'hF, 16'h0001 << IFB_B1_ADC_B_DONE, IFB_RESP_OKAY);
		rd_chk(A1, 32'h00000020, IFB_RESP_OKAY);
		rd_chk(AS, 32'h1 << IFB_EV_REQ_ONE | 32'h1 << IFB_EV_COLLIDE, IFB_RESP_OKAY);
		$display("test collision ended");
		@(negedge clk);
		chk_val({31'h0, irq}, 32'h0);
		axi_write(AM, 32'h1, 4'hF, 16'h0, IFB_RESP_OKAY);
		@(negedge clk);
		chk_val({31'h0, irq}, 32'h1);
		axi_write(AS, 32'h1, 4'hF, 16'h0, IFB_RESP_OKAY);
		@(negedge clk);
		chk_val({31'h0, irq}, 32'h0);
		rd_chk(AS, 32'h1 << IFB_EV_COLLIDE, IFB_RESP_OKAY);
		rd_chk(AM, 32'h1, IFB_RESP_OKAY);
		axi_write(8'h10, 32'hFFFF, 4'hF, 16'h0, IFB_RESP_SLVERR);
		rd_chk(8'h10, 32'h0, IFB_RESP_SLVERR);
		rd_chk(8'h02, 32'h0, IFB_RESP_SLVERR);
		rd_chk(A1, 32'h00000020, IFB_RESP_OKAY);
		$display("test interrupt and decode ended");
		axi_write(AS, 32'h7, 4'hF, 16'h0, IFB_RESP_OKAY);
		axi_write(A2, 32'h0, 4'h1, 16'h0001 << IFB_B2_CAN_A_EVENT, IFB_RESP_OKAY);
		rd_chk(A2, 32'h1 << IFB_B2_CAN_A_EVENT, IFB_RESP_OKAY);
		rd_chk(AS, 32'h1 << IFB_EV_REQ_TWO | 32'h1 << IFB_EV_COLLIDE, IFB_RESP_OKAY);
		$display("test second register collision ended");
		test_done();
	end
endmodule // interrupt_flag_bank_one_two_tb
